// >>> verilog/gpio_lock_pkg.sv
// constants shared by the port clear, lock, speed and event routing block
// assumes a single 25 MHz clock and an Avalon-MM register slave
package gpio_lock_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] EVT_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] OUT_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] CLR_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] LOCK_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] SPD_OFS = 8'h3c;
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h40;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [3:0] FULL_WORD = 4'hf;
  // ****************************************
  // field layout
  // ****************************************
  localparam int PIN_W = 16;
  localparam int KEY_BIT = 16;
  localparam int EVT_W = 8;
  localparam int EVT_EN_BIT = 7;
  localparam int EVT_PORT_LSB = 4;
  localparam int EVT_PORT_W = 3;
  localparam int EVT_PIN_LSB = 0;
  localparam int EVT_PIN_W = 4;
  localparam int EVT_PORTS = 5;
  localparam logic [1:0] MODE_FAST = 2'h3;
  // ****************************************
  // lock key sequence states
  // ****************************************
  typedef enum logic [1:0] {KEY_IDLE, KEY_W1, KEY_W2, KEY_R0} key_state_e;
endpackage

// >>> verilog/lock_key_seq.sv
// lock key sequencer: tracks the write, write, read, read pattern
// assumes write and read strobes are one-cycle accepted bus transfers
`timescale 1ns/1ps
module lock_key_seq #(
  parameter int PINS = gpio_lock_pkg::PIN_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // accepted accesses to the lock register
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic wr_key_in,
  input wire logic [PINS-1:0] wr_pins_in,
  input wire logic [PINS-1:0] pins_now_in,
  // key state
  output logic key_out,
  output logic read_key_out
);
  if (PINS < 1 || PINS > 16) begin : g_bad_pins
    $error("PINS out of range");
  end

  gpio_lock_pkg::key_state_e state_q, state_d;
  logic key_q;
  wire same_pins = (wr_pins_in == pins_now_in);
  wire key_write = wr_in & wr_key_in;

  // key sequence, any other access restarts it
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      gpio_lock_pkg::KEY_IDLE: if (key_write) state_d = gpio_lock_pkg::KEY_W1;
      gpio_lock_pkg::KEY_W1: begin
        if (wr_in) state_d = (key_write & same_pins) ? gpio_lock_pkg::KEY_W2
                           : key_write ? gpio_lock_pkg::KEY_W1 : gpio_lock_pkg::KEY_IDLE;
        else if (rd_in) state_d = gpio_lock_pkg::KEY_IDLE;
      end
      gpio_lock_pkg::KEY_W2: begin
        if (rd_in) state_d = gpio_lock_pkg::KEY_R0;
        else if (wr_in) state_d = key_write ? gpio_lock_pkg::KEY_W1 : gpio_lock_pkg::KEY_IDLE;
      end
      gpio_lock_pkg::KEY_R0: begin
        if (rd_in) state_d = gpio_lock_pkg::KEY_IDLE;
        else if (wr_in) state_d = key_write ? gpio_lock_pkg::KEY_W1 : gpio_lock_pkg::KEY_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q <= gpio_lock_pkg::KEY_IDLE;
      key_q <= 1'b0;
    end else begin
      state_q <= key_q ? gpio_lock_pkg::KEY_IDLE : state_d;
      if (rd_in && state_q == gpio_lock_pkg::KEY_R0) key_q <= 1'b1;
    end
  end

  assign key_out = key_q;
  // the final read of the sequence already reports one
  assign read_key_out = key_q | (state_q == gpio_lock_pkg::KEY_R0);
endmodule

// >>> verilog/event_route.sv
// event router: drives the core event onto one selected port pin
// assumes the core event is synchronous to the system clock
`timescale 1ns/1ps
module event_route #(
  parameter int PORTS = gpio_lock_pkg::EVT_PORTS,
  parameter int PINS = gpio_lock_pkg::PIN_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // selection
  input wire logic enable_in,
  input wire logic [gpio_lock_pkg::EVT_PORT_W-1:0] port_sel_in,
  input wire logic [gpio_lock_pkg::EVT_PIN_W-1:0] pin_sel_in,
  // event
  input wire logic core_event_signal_in,
  output logic [PORTS*PINS-1:0] route_out
);
  if (PORTS < 1 || PORTS > 8 || PINS != 16) begin : g_bad_size
    $error("router size not supported");
  end

  localparam int PSEL_W = gpio_lock_pkg::EVT_PORT_W;
  localparam int NSEL_W = gpio_lock_pkg::EVT_PIN_W;

  logic [PORTS*PINS-1:0] route_q;
  logic [PORTS*PINS-1:0] route_d;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    for (genvar n = 0; n < PINS; n++) begin : g_pin
      assign route_d[p*PINS+n] = enable_in & core_event_signal_in
        & (port_sel_in == PSEL_W'(p))
        & (pin_sel_in == NSEL_W'(n));
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) route_q <= '0;
    else route_q <= route_d;
  end

  assign route_out = route_q;
endmodule

// >>> verilog/gpio_clear_lock_speed_core_event_signal.sv
// port output clear, configuration lock, very-high-speed select and event routing
// assumes an Avalon-MM master on sys_clk_in and synchronous inputs
`timescale 1ns/1ps
module gpio_clear_lock_speed_core_event_signal #(
  parameter int PINS = gpio_lock_pkg::PIN_W,
  parameter int PORTS = gpio_lock_pkg::EVT_PORTS
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [gpio_lock_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // core event
  input wire logic core_event_signal_in,
  // pin controls
  output logic [PINS-1:0] output_level_bits_out,
  output logic [2*PINS-1:0] pin_mode_field_out,
  output logic [PINS-1:0] pin_locked_out,
  output logic [PINS-1:0] very_high_speed_out,
  output logic lock_sequence_key_out,
  output logic [PORTS*PINS-1:0] event_route_out
);
  if (PINS != 16) begin : g_bad_pins
    $error("only 16 pins supported");
  end

  // ****************************************
  // bus decode
  // ****************************************
  logic ack_q;
  logic [31:0] rdata_q;
  wire req = avs_read_in | avs_write_in;
  wire accept = req & ack_q;
  wire full_word = (avs_byteenable_in == gpio_lock_pkg::FULL_WORD);
  wire wr_ok = accept & avs_write_in & full_word;
  wire rd_ok = accept & avs_read_in;
  wire sel_evt = (avs_address_in == gpio_lock_pkg::EVT_OFS);
  wire sel_out = (avs_address_in == gpio_lock_pkg::OUT_OFS);
  wire sel_clr = (avs_address_in == gpio_lock_pkg::CLR_OFS);
  wire sel_lock = (avs_address_in == gpio_lock_pkg::LOCK_OFS);
  wire sel_spd = (avs_address_in == gpio_lock_pkg::SPD_OFS);
  wire sel_mode = (avs_address_in == gpio_lock_pkg::MODE_OFS);
  wire [PINS-1:0] wd_pins = avs_writedata_in[PINS-1:0];

  assign avs_waitrequest_out = req & ~ack_q;

  // ****************************************
  // registers
  // ****************************************
  logic [gpio_lock_pkg::EVT_W-1:0] evt_q;
  logic [PINS-1:0] out_q;
  logic [PINS-1:0] pin_lock_q;
  logic [PINS-1:0] spd_q;
  logic [2*PINS-1:0] mode_q;
  logic [PINS-1:0] vhs_q;
  logic key;
  logic read_key;

  wire [PINS-1:0] locked = pin_lock_q & {PINS{key}};
  logic [2*PINS-1:0] mode_keep;
  logic [PINS-1:0] fast_mode;
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign mode_keep[2*i +: 2] = {2{locked[i]}};
    assign fast_mode[i] = (mode_q[2*i +: 2] == gpio_lock_pkg::MODE_FAST);
  end

  wire [2*PINS-1:0] mode_d = (mode_q & mode_keep) | (avs_writedata_in & ~mode_keep);
  wire [PINS-1:0] out_d = sel_clr ? (out_q & ~wd_pins) : wd_pins;
  wire [PINS-1:0] vhs_d = spd_q & fast_mode;

  wire [31:0] rd_mux =
    sel_evt ? {24'h00_0000, evt_q} :
    sel_out ? {16'h0000, out_q} :
    sel_lock ? {15'h0000, read_key, pin_lock_q} :
    sel_spd ? {16'h0000, spd_q} :
    sel_mode ? mode_q : gpio_lock_pkg::REG_RESET;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) ack_q <= 1'b0;
    else ack_q <= req & ~ack_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) rdata_q <= gpio_lock_pkg::REG_RESET;
    else if (avs_read_in && !ack_q) rdata_q <= rd_mux;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      evt_q <= '0;
      out_q <= '0;
      spd_q <= '0;
      mode_q <= '0;
    end else begin
      if (wr_ok && sel_evt) evt_q <= avs_writedata_in[gpio_lock_pkg::EVT_W-1:0];
      if (wr_ok && (sel_out || sel_clr)) out_q <= out_d;
      if (wr_ok && sel_spd) spd_q <= wd_pins;
      if (wr_ok && sel_mode) mode_q <= mode_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) pin_lock_q <= '0;
    else if (wr_ok && sel_lock && !key) pin_lock_q <= wd_pins;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) vhs_q <= '0;
    else vhs_q <= vhs_d;
  end

  // ****************************************
  // lock key and event router
  // ****************************************
  lock_key_seq #(.PINS(PINS)) u_key (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(wr_ok & sel_lock & ~key),
    .rd_in(rd_ok & sel_lock),
    .wr_key_in(avs_writedata_in[gpio_lock_pkg::KEY_BIT]),
    .wr_pins_in(wd_pins),
    .pins_now_in(pin_lock_q),
    .key_out(key),
    .read_key_out(read_key)
  );

  event_route #(.PORTS(PORTS), .PINS(PINS)) u_route (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .enable_in(evt_q[gpio_lock_pkg::EVT_EN_BIT]),
    .port_sel_in(evt_q[gpio_lock_pkg::EVT_PORT_LSB +: gpio_lock_pkg::EVT_PORT_W]),
    .pin_sel_in(evt_q[gpio_lock_pkg::EVT_PIN_LSB +: gpio_lock_pkg::EVT_PIN_W]),
    .core_event_signal_in(core_event_signal_in),
    .route_out(event_route_out)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata_out = rdata_q;
  assign output_level_bits_out = out_q;
  assign pin_mode_field_out = mode_q;
  assign pin_locked_out = locked;
  assign very_high_speed_out = vhs_q;
  assign lock_sequence_key_out = key;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  clear_bits_a: assert property (
    wr_ok && sel_clr |=> (out_q & $past(wd_pins)) == '0)
    else $error("clear write left an output bit set");

  clear_keep_a: assert property (
    wr_ok && sel_clr |=> (out_q & ~$past(wd_pins)) == ($past(out_q) & ~$past(wd_pins)))
    else $error("clear write disturbed an unselected bit");

  key_only_seq_a: assert property (
    $rose(key) |-> $past(rd_ok && sel_lock && read_key))
    else $error("lock key set outside the sequence");

  key_sticky_a: assert property (
    key |=> key)
    else $error("lock key dropped before reset");

  // watches lock accesses spaced by one idle cycle only
  sequence key_writes;
    wr_ok && sel_lock && avs_writedata_in[gpio_lock_pkg::KEY_BIT] ##1 !req ##1 req && !ack_q
      ##1 wr_ok && sel_lock && avs_writedata_in[gpio_lock_pkg::KEY_BIT] && wd_pins == pin_lock_q;
  endsequence
  key_seq_read0_a: assert property (
    !key ##0 key_writes ##1 !req ##1 (avs_read_in && sel_lock && !ack_q) |=> !rdata_q[gpio_lock_pkg::KEY_BIT])
    else $error("third step of key sequence did not read zero");

  key_read1_a: assert property (
    $rose(key) |-> rdata_q[gpio_lock_pkg::KEY_BIT])
    else $error("lock key set without reading one");

  key_readable_a: assert property (
    rd_ok && sel_lock && key |-> rdata_q[gpio_lock_pkg::KEY_BIT])
    else $error("set lock key not readable");

  clear_reads_zero_a: assert property (
    rd_ok && sel_clr |-> rdata_q == gpio_lock_pkg::REG_RESET)
    else $error("bit clear register read back nonzero");

  part_write_a: assert property (
    accept && avs_write_in && !full_word |=> $stable(out_q) && $stable(evt_q) && $stable(spd_q)
      && $stable(mode_q) && $stable(pin_lock_q))
    else $error("partial write changed a register");

  lock_write_lands_a: assert property (
    !key && wr_ok && sel_lock |=> pin_lock_q == $past(wd_pins))
    else $error("pin lock bits not written while unlocked");

  speed_write_a: assert property (
    wr_ok && sel_spd |=> spd_q == $past(wd_pins))
    else $error("speed bits not written");

  event_pulse_a: assert property (
    event_route_out != '0 |-> $past(core_event_signal_in && evt_q[gpio_lock_pkg::EVT_EN_BIT]))
    else $error("routed pin high without an enabled event");

  wait_first_a: assert property (
    req && !ack_q |-> avs_waitrequest_out)
    else $error("slave answered in the first request cycle");

  lock_frozen_a: assert property (
    key && wr_ok && sel_lock |=> $stable(pin_lock_q))
    else $error("lock register changed after key set");

  mode_locked_a: assert property (
    wr_ok && sel_mode |=> ((mode_q ^ $past(mode_q)) & $past(mode_keep)) == '0)
    else $error("locked pin mode field changed");

  speed_sel_a: assert property (
    ##1 very_high_speed_out == $past(spd_q & fast_mode))
    else $error("very high speed select wrong");

  event_route_a: assert property (
    evt_q[gpio_lock_pkg::EVT_EN_BIT] && core_event_signal_in
      && evt_q[gpio_lock_pkg::EVT_PORT_LSB +: gpio_lock_pkg::EVT_PORT_W] < 3'h5
    |=> $onehot(event_route_out))
    else $error("enabled event not routed to one pin");

  event_off_a: assert property (
    !evt_q[gpio_lock_pkg::EVT_EN_BIT] || !core_event_signal_in
      || evt_q[gpio_lock_pkg::EVT_PORT_LSB +: gpio_lock_pkg::EVT_PORT_W] > 3'h4
    |=> event_route_out == '0)
    else $error("event routed while disabled or port invalid");

  event_pin_a: assert property (
    evt_q[gpio_lock_pkg::EVT_EN_BIT] && core_event_signal_in
      && evt_q[gpio_lock_pkg::EVT_PORT_LSB +: gpio_lock_pkg::EVT_PORT_W] == 3'h0
    |=> event_route_out[$past(evt_q[gpio_lock_pkg::EVT_PIN_LSB +: gpio_lock_pkg::EVT_PIN_W])])
    else $error("event routed to wrong pin");

  bus_answer_a: assert property (
    req && !ack_q |=> !avs_waitrequest_out)
    else $error("slave did not answer in one cycle");

  key_set_c: cover property ($rose(key));
  clear_write_c: cover property (wr_ok && sel_clr && out_q != '0);
  event_routed_c: cover property (event_route_out != '0);
  locked_mode_write_c: cover property (wr_ok && sel_mode && locked != '0);
  part_write_c: cover property (accept && avs_write_in && !full_word);
endmodule

// >>> tb/pin_partner.sv
// pin side model: core event source and monitor of routed pins
// assumes the bench raises go_in for one cycle per event
`timescale 1ns/1ps
module pin_partner (
  // clock
  input wire logic sys_clk_in,
  // bench control
  input wire logic go_in,
  // pins
  input wire logic [79:0] route_in,
  output logic core_event_out,
  output logic [79:0] hit_out
);
  // latch the last non-idle pin pattern, cleared per event
  always_ff @(posedge sys_clk_in) begin
    core_event_out <= go_in;
    if (go_in) begin
      hit_out <= 80'h0;
    end else if (|route_in) begin
      hit_out <= route_in;
    end
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench for clear, lock, speed and event routing
// assumes the design files and pin_partner are compiled first
`timescale 1ns/1ps
module testbench;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat, mode, got, a, b, m;
  logic wreq, evt, key;
  logic go = 1'b0;
  logic [15:0] lvl, lockd, vhs, lockset;
  logic [79:0] route, hit;
  logic [31:0] seed = 32'h810b;
  logic [7:0] offs [7] = '{8'h00, 8'h0c, 8'h14, 8'h18, 8'h3c, 8'h40, 8'h24};
  int bad_count = 0;
  int check_count = 0;
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  gpio_clear_lock_speed_core_event_signal i_gpio_clear_lock_speed_core_event_signal (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .core_event_signal_in(evt), .output_level_bits_out(lvl), .pin_mode_field_out(mode),
    .pin_locked_out(lockd), .very_high_speed_out(vhs), .lock_sequence_key_out(key),
    .event_route_out(route));
  pin_partner i_pin_partner (.sys_clk_in(sys_clk_in), .go_in(go), .route_in(route),
    .core_event_out(evt), .hit_out(hit));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0);
  endfunction
  task automatic draw(output logic [31:0] v);
    seed = lfsr(seed);
    v = seed;
  endtask
  task automatic chk(input logic [79:0] exp, input logic [79:0] act);
    check_count++;
    if (act !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d, input logic [3:0] e);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    adr <= ad;
    wr <= w;
    rd <= !w;
    wdat <= d;
    be <= e;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) chk(80'h1, 80'h0);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge sys_clk_in);
  endtask
  function automatic logic [15:0] fast_exp(input logic [15:0] s, input logic [31:0] md);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = s[i] & (md[2*i+:2] == 2'h3);
    return r;
  endfunction
  function automatic logic [79:0] route_exp(input logic [7:0] c);
    return (c[7] && c[6:4] < 3'h5) ? (80'h1 << (c[6:4] * 16 + c[3:0])) : 80'h0;
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    bad_count++;
    close_out();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    foreach (offs[i]) begin
      xfer(offs[i], 1'b0, 32'h0, 4'hf);
      chk(80'h0, got);
    end
    chk(80'h0, {lvl, lockd, vhs, key});
    chk(80'h0, mode);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      draw(a);
      draw(b);
      if (k == 0) b = 32'h0000_ffff;
      xfer(8'h0c, 1'b1, {16'h0, a[15:0]}, 4'hf);
      xfer(8'h14, 1'b1, {16'h0, b[15:0]}, 4'hf);
      chk(a[15:0] & ~b[15:0], lvl);
      xfer(8'h14, 1'b0, 32'h0, 4'hf);
      chk(80'h0, got);
    end
    a = {16'h0, lvl};
    xfer(8'h0c, 1'b1, 32'h0000_ffff, 4'h3);
    chk(a, lvl);
    $display("test clear done");
    for (int k = 0; k < 6; k++) begin
      draw(m);
      draw(b);
      if (k == 0) m = 32'hffff_ffff;
      xfer(8'h40, 1'b1, m, 4'hf);
      xfer(8'h3c, 1'b1, {16'h0, b[15:0]}, 4'hf);
      @(negedge sys_clk_in);
      chk(fast_exp(b[15:0], m), vhs);
      chk(m, mode);
    end
    $display("test speed done");
    for (int k = 0; k < 9; k++) begin
      draw(a);
      a[7:4] = (k < 8) ? {1'b1, k[2:0]} : 4'h0;
      if (k == 4) a[3:0] = 4'hf;
      xfer(8'h00, 1'b1, {24'h0, a[7:0]}, 4'hf);
      @(posedge sys_clk_in);
      go <= 1'b1;
      @(posedge sys_clk_in);
      go <= 1'b0;
      repeat (3) @(negedge sys_clk_in);
      chk(route_exp(a[7:0]), hit);
    end
    $display("test event done");
    draw(a);
    lockset = (a[15:0] | 16'h0001) & 16'h7fff;
    xfer(8'h18, 1'b1, {15'h0, 1'b1, lockset}, 4'hf);
    xfer(8'h18, 1'b0, 32'h0, 4'hf);
    chk({15'h0, 1'b0, lockset}, got);
    chk(80'h0, {key, lockd});
    xfer(8'h18, 1'b1, {15'h0, 1'b1, lockset}, 4'hf);
    xfer(8'h18, 1'b1, {15'h0, 1'b1, lockset}, 4'hf);
    xfer(8'h18, 1'b0, 32'h0, 4'hf);
    chk({15'h0, 1'b0, lockset}, got);
    xfer(8'h18, 1'b0, 32'h0, 4'hf);
    chk({15'h0, 1'b1, lockset}, got);
    chk({1'b1, lockset}, {key, lockd});
    xfer(8'h18, 1'b1, 32'h0, 4'hf);
    xfer(8'h18, 1'b0, 32'h0, 4'hf);
    chk({15'h0, 1'b1, lockset}, got);
    draw(b);
    xfer(8'h40, 1'b1, b, 4'hf);
    for (int i = 0; i < 16; i++) if (!lockset[i]) m[2*i+:2] = b[2*i+:2];
    xfer(8'h40, 1'b0, 32'h0, 4'hf);
    chk(m, got);
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(80'h0, {key, lockd});
    xfer(8'h18, 1'b1, {16'h0, lockset}, 4'hf);
    xfer(8'h18, 1'b0, 32'h0, 4'hf);
    chk({16'h0, lockset}, got);
    $display("test lock done");
    close_out();
  end
endmodule
